// >>> dcw_ctrl.sv
// Control word upper bit decoder with AXI4-Lite register access
`timescale 1ns/100ps
module dcw_ctrl
  import dcw_pkg::*;
#(
  parameter int unsigned FAULT_DELAY = FAULT_DELAY_CYC,
  parameter int unsigned TICKS_PER_MS = CLK_HZ / 1000
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // AXI4-Lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  // AXI4-Lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Drive outputs
  output logic             fault_active,
  output logic             pulse_inhibit,
  output logic             contactor_open,
  output logic             slave_torque,
  output logic             master_speed,
  output logic             alarm_one,
  output logic             alarm_two,
  output logic             param_set_two,
  output logic             contactor_confirmed,
  output logic             irq
);
  typedef struct packed {
    logic [31:0]     cw;
    logic [7:0]      cfg;
    logic [15:0]     cbk_ms;
    logic [IRQ_W-1:0] ist;
    logic [IRQ_W-1:0] imask;
    dcw_fstate_t     fst;
    logic [31:0]     dly;
    logic            cbk_wait;
    logic            cbk_ok;
    logic            smp_fault;
    logic            smp_slave;
    logic            smp_al1;
    logic            smp_al2;
    logic            smp_set;
    logic            smp_cbk;
    logic            aw_got;
    logic [7:0]      aw_addr;
    logic            w_got;
    logic [31:0]     w_data;
    logic [3:0]      w_strb;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            rvalid;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
    logic            out_slave;
    logic            out_master;
  } dcw_state_t;

  dcw_state_t s_q, s_d;
  logic       tmr_expired;
  logic       cbk_start;
  logic       cbk_stop;

  // Byte-lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction : merge

  function automatic logic closed_loop(input logic [3:0] ct);
    return (ct == CTYPE_FREQ_CL) || (ct == CTYPE_SPEED_CL);
  endfunction : closed_loop

  dcw_ms_timer #(
    .TICKS_PER_MS(TICKS_PER_MS)
  ) u_cbk_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .start   (cbk_start),
    .stop    (cbk_stop),
    .time_ms (s_q.cbk_ms),
    .expired (tmr_expired)
  );

  // Checkback window opens when closing is requested, stops on checkback
  assign cbk_start = !s_q.cbk_wait && !s_q.cbk_ok && s_q.cfg[CFG_CONT_FITTED]
                     && s_q.cfg[CFG_READY] && (s_q.fst != DCW_FAULT);
  assign cbk_stop  = s_q.smp_cbk || !s_q.cfg[CFG_CONT_FITTED];

  always_comb begin
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr;
    logic             do_wr;
    logic [31:0]      wv;
    logic             pulses_on;
    ev        = '0;
    clr       = '0;
    do_wr     = 1'b0;
    wv        = '0;
    s_d       = s_q;

    // Sample the command bits once per cycle
    s_d.smp_fault = s_q.cw[BIT_EXT_FAULT2];
    s_d.smp_slave = s_q.cw[BIT_SLAVE];
    s_d.smp_al1   = s_q.cw[BIT_EXT_ALARM1];
    s_d.smp_al2   = s_q.cw[BIT_EXT_ALARM2];
    s_d.smp_set   = s_q.cw[BIT_SET_SEL];
    s_d.smp_cbk   = s_q.cw[BIT_CHECKBACK];

    // External fault qualification
    unique case (s_q.fst)
      DCW_RUN: begin
        s_d.dly = '0;
        if (!s_q.smp_fault && s_q.cfg[CFG_READY]) s_d.fst = DCW_DELAY;
      end
      DCW_DELAY: begin
        if (s_q.smp_fault || !s_q.cfg[CFG_READY]) begin
          s_d.fst = DCW_RUN;
        end else if (s_q.dly == FAULT_DELAY - 1) begin
          s_d.fst = DCW_FAULT;
          ev[IRQ_FAULT] = 1'b1;
        end else begin
          s_d.dly = s_q.dly + 32'h0000_0001;
        end
      end
      DCW_FAULT: begin
        if (s_q.cfg[CFG_FAULT_ACK] && s_q.smp_fault) s_d.fst = DCW_RUN;
      end
      default: s_d.fst = DCW_RUN;
    endcase

    // Torque or speed mode only when closed loop and pulses run
    pulses_on    = s_q.cfg[CFG_PULSE_EN] && (s_q.fst != DCW_FAULT);
    s_d.out_slave  = s_q.smp_slave && closed_loop(s_q.cfg[CFG_CTYPE_LSB +: 4]) && pulses_on;
    s_d.out_master = !s_q.smp_slave && closed_loop(s_q.cfg[CFG_CTYPE_LSB +: 4]) && pulses_on;

    // Alarm events only flag, state is untouched
    ev[IRQ_ALARM1] = !s_q.smp_al1;
    ev[IRQ_ALARM2] = !s_q.smp_al2;

    // Contactor checkback
    if (cbk_stop) begin
      s_d.cbk_wait = 1'b0;
    end else if (cbk_start) begin
      s_d.cbk_wait = 1'b1;
    end
    // A checkback already high when the window opens confirms at once,
    // otherwise stop would block the start and the window would never open
    if ((s_q.cbk_wait || cbk_start) && s_q.smp_cbk) s_d.cbk_ok = 1'b1;
    if (!s_q.cfg[CFG_CONT_FITTED] || s_q.fst == DCW_FAULT || !s_q.smp_cbk) s_d.cbk_ok = 1'b0;
    if (tmr_expired) begin
      s_d.cbk_wait = 1'b0;
      ev[IRQ_CBK_TIMEOUT] = 1'b1;
    end

    // AXI write path
    s_d.bvalid = s_q.bvalid && !s_axi_bready;
    if (s_axi_awvalid && !s_q.aw_got) begin
      s_d.aw_got  = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_got) begin
      s_d.w_got  = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
      do_wr      = 1'b1;
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = RESP_OKAY;
      unique case ({s_q.aw_addr[7:2], 2'b00})
        ADDR_CTRL_WORD: s_d.cw = merge(s_q.cw, s_q.w_data, s_q.w_strb);
        ADDR_CONFIG: begin
          wv = merge({24'h00_0000, s_q.cfg}, s_q.w_data, s_q.w_strb);
          s_d.cfg = wv[7:0];
        end
        ADDR_CBK_TIME: begin
          wv = merge({16'h0000, s_q.cbk_ms}, s_q.w_data, s_q.w_strb);
          s_d.cbk_ms = wv[15:0];
        end
        ADDR_IRQ_STAT: if (s_q.w_strb[0]) clr = s_q.w_data[IRQ_W-1:0];
        ADDR_IRQ_MASK: if (s_q.w_strb[0]) s_d.imask = s_q.w_data[IRQ_W-1:0];
        ADDR_STATUS, ADDR_CODES: ;
        default: s_d.bresp = RESP_SLVERR;
      endcase
    end
    // Acknowledge bit is a one-shot request
    if (!do_wr) s_d.cfg[CFG_FAULT_ACK] = 1'b0;

    // Sticky status, set wins over clear
    s_d.ist = (s_q.ist & ~clr) | ev;

    // AXI read path
    s_d.rvalid = s_q.rvalid && !s_axi_rready;
    if (s_axi_arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = RESP_OKAY;
      s_d.rdata  = '0;
      unique case ({s_axi_araddr[7:2], 2'b00})
        ADDR_CTRL_WORD: s_d.rdata = s_q.cw;
        ADDR_CONFIG:    s_d.rdata = {24'h00_0000, s_q.cfg};
        ADDR_CBK_TIME:  s_d.rdata = {16'h0000, s_q.cbk_ms};
        ADDR_STATUS:    s_d.rdata = {22'h00_0000, s_q.cbk_wait, s_q.cbk_ok,
                                     s_q.smp_set, !s_q.smp_al2, !s_q.smp_al1,
                                     s_q.out_master, s_q.out_slave, s_q.fst};
        ADDR_IRQ_STAT:  s_d.rdata = {28'h000_0000, s_q.ist};
        ADDR_IRQ_MASK:  s_d.rdata = {28'h000_0000, s_q.imask};
        ADDR_CODES:     s_d.rdata = {8'h00,
                                     (!s_q.smp_al2) ? EXT_ALARM_TWO_CODE : 8'h00,
                                     (!s_q.smp_al1) ? EXT_ALARM_ONE_CODE : 8'h00,
                                     (s_q.fst == DCW_FAULT) ? EXT_FAULT_TWO_CODE : 8'h00};
        default:        s_d.rresp = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q        <= '0;
      s_q.cw     <= CTRL_WORD_RST;
      s_q.fst    <= DCW_RUN;
      s_q.cbk_ms <= 16'(CBK_TIME_MS_RST);
      s_q.smp_fault <= 1'b1;
      s_q.smp_al1   <= 1'b1;
      s_q.smp_al2   <= 1'b1;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // Handshake outputs
  assign s_axi_awready = !s_q.aw_got;
  assign s_axi_wready  = !s_q.w_got;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;

  // Drive outputs
  assign fault_active        = (s_q.fst == DCW_FAULT);
  assign pulse_inhibit       = (s_q.fst == DCW_FAULT);
  assign contactor_open      = (s_q.fst == DCW_FAULT) && s_q.cfg[CFG_CONT_FITTED];
  assign slave_torque        = s_q.out_slave;
  assign master_speed        = s_q.out_master;
  assign alarm_one           = !s_q.smp_al1;
  assign alarm_two           = !s_q.smp_al2;
  assign param_set_two       = s_q.smp_set;
  assign contactor_confirmed = s_q.cbk_ok;
  assign irq                 = |(s_q.ist & s_q.imask);
endmodule : dcw_ctrl

// >>> dcw_pkg.sv
// Package with register map, field positions and timing for the control word decoder
//
// Summary of operation
// - Low fault bit in ready, 200 ms, then fault
// - Taken fault blocks pulses and opens contactor
// - Slave bit high, closed loop, pulses: torque
// - Slave bit low, closed loop, pulses: speed
// - Low alarm 1 bit keeps state, raises alarm
// - Low alarm 2 bit keeps state, raises alarm
// - Set select bit picks parameter set two
// - Checkback high within set time confirms contactor
package dcw_pkg;
  localparam int unsigned CLK_HZ            = 50_000_000;
  localparam int unsigned FAULT_DELAY_MS    = 200;
  localparam int unsigned FAULT_DELAY_CYC   = (CLK_HZ / 1000) * FAULT_DELAY_MS;
  localparam int unsigned CBK_TIME_MS_RST   = 500;

  // Control word bit positions
  localparam int unsigned BIT_EXT_FAULT2    = 26;
  localparam int unsigned BIT_SLAVE         = 27;
  localparam int unsigned BIT_EXT_ALARM1    = 28;
  localparam int unsigned BIT_EXT_ALARM2    = 29;
  localparam int unsigned BIT_SET_SEL       = 30;
  localparam int unsigned BIT_CHECKBACK     = 31;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL_WORD     = 8'h00;
  localparam logic [7:0] ADDR_CONFIG        = 8'h04;
  localparam logic [7:0] ADDR_CBK_TIME      = 8'h08;
  localparam logic [7:0] ADDR_STATUS        = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STAT      = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK      = 8'h14;
  localparam logic [7:0] ADDR_CODES         = 8'h18;

  // Config fields
  localparam int unsigned CFG_CTYPE_LSB     = 0;
  localparam int unsigned CFG_PULSE_EN      = 4;
  localparam int unsigned CFG_CONT_FITTED   = 5;
  localparam int unsigned CFG_READY         = 6;
  localparam int unsigned CFG_FAULT_ACK     = 7;
  localparam logic [3:0] CTYPE_FREQ_CL      = 4'h3;
  localparam logic [3:0] CTYPE_SPEED_CL     = 4'h4;

  // Interrupt status bit positions
  localparam int unsigned IRQ_FAULT         = 0;
  localparam int unsigned IRQ_ALARM1        = 1;
  localparam int unsigned IRQ_ALARM2        = 2;
  localparam int unsigned IRQ_CBK_TIMEOUT   = 3;
  localparam int unsigned IRQ_W             = 4;

  localparam logic [31:0] CTRL_WORD_RST     = 32'hFC00_0000;
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;

  // Message codes, numeric forms of the documented code numbers
  localparam logic [7:0] EXT_FAULT_TWO_CODE = 8'h24;
  localparam logic [7:0] EXT_ALARM_ONE_CODE = 8'h0F;
  localparam logic [7:0] EXT_ALARM_TWO_CODE = 8'h10;

  typedef enum logic [2:0] {
    DCW_RUN   = 3'b001,
    DCW_DELAY = 3'b010,
    DCW_FAULT = 3'b100
  } dcw_fstate_t;
endpackage : dcw_pkg

// >>> dcw_ms_timer.sv
// Millisecond-resolution down counter for the contactor checkback window
`timescale 1ns/100ps
module dcw_ms_timer
  import dcw_pkg::*;
#(
  parameter int unsigned TICKS_PER_MS = CLK_HZ / 1000
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // Control
  input  wire logic        start,
  input  wire logic        stop,
  input  wire logic [15:0] time_ms,
  // Result
  output logic             expired
);
  typedef struct packed {
    logic [31:0] tick;
    logic [15:0] ms;
    logic        run;
    logic        exp;
  } dcw_tmr_t;

  dcw_tmr_t s_q, s_d;

  always_comb begin
    s_d     = s_q;
    s_d.exp = 1'b0;
    if (stop) begin
      s_d.run = 1'b0;
    end else if (start) begin
      s_d.run  = 1'b1;
      s_d.ms   = time_ms;
      s_d.tick = '0;
    end else if (s_q.run) begin
      if (s_q.tick == TICKS_PER_MS - 1) begin
        s_d.tick = '0;
        if (s_q.ms == 16'h0000) begin
          s_d.run = 1'b0;
          s_d.exp = 1'b1;
        end else begin
          s_d.ms = s_q.ms - 16'h0001;
        end
      end else begin
        s_d.tick = s_q.tick + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign expired = s_q.exp;
endmodule : dcw_ms_timer

// >>> dcw_checker.sv
// Concurrent checks on the control word decoder ports
`timescale 1ns/100ps
module dcw_checker (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Bus handshakes
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Drive outputs
  input wire logic fault_active,
  input wire logic pulse_inhibit,
  input wire logic contactor_open,
  input wire logic slave_torque,
  input wire logic master_speed
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence r_waiting;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  sequence b_taken;
    s_axi_bvalid && s_axi_bready;
  endsequence
  pulse_inh_a: assert property (pulse_inhibit == fault_active)
    else $error("pulse inhibit differs from fault state");
  cont_open_a: assert property (contactor_open |-> fault_active)
    else $error("contactor opened without fault");
  mode_excl_a: assert property (!(slave_torque && master_speed))
    else $error("slave and master modes both active");
  rd_latency_a: assert property (ar_taken |=> s_axi_rvalid)
    else $error("read data late");
  rd_hold_a: assert property (r_waiting |=> s_axi_rvalid)
    else $error("read data dropped before taken");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while data pending");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before taken");
  b_release_a: assert property (b_taken |=> !s_axi_bvalid)
    else $error("write response repeated");
endmodule : dcw_checker

bind dcw_ctrl dcw_checker u_dcw_checker (.*);

// >>> dcw_host.sv
// Host controller model driving the register bus
`timescale 1ns/100ps
module dcw_host (
  // Clock
  input wire logic aclk,
  // Write side
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // Read side
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  output logic [7:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp
);
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
  end
  // Released addresses and write data are inverted so stale values are never mistaken for live ones
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hF};
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
      if (s_axi_wvalid && s_axi_wready) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    {s_axi_arvalid, s_axi_rready, s_axi_araddr} <= {2'h3, a};
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
      if (s_axi_rvalid) begin
        {d, r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask : rd
endmodule : dcw_host

// >>> drive_control_word_upper_bits_bench.sv
// Self-checking bench for the control word decoder
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module drive_control_word_upper_bits_bench;
  import dcw_pkg::*;
  typedef struct {logic [31:0] m; logic [31:0] v;} dcw_exp_t;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed = 32'h36A6E0D9;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic fault_active, pulse_inhibit, contactor_open, slave_torque, master_speed;
  logic alarm_one, alarm_two, param_set_two, contactor_confirmed, irq;
  int miscompares = 0, samples_checked = 0, cyc = 0;
  dcw_exp_t exp_q[$];

  dcw_ctrl #(.FAULT_DELAY(20), .TICKS_PER_MS(4)) u_dcw_ctrl (.*);
  dcw_host u_dcw_host (.*);

  always #10 aclk = ~aclk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic wrap_up;
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    u_dcw_host.wr(a, d, r);
    `CHK(r, (a > ADDR_CODES) ? RESP_SLVERR : RESP_OKAY)
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    logic [31:0] d;
    logic [1:0] r;
    exp_q.push_back('{m, v});
    u_dcw_host.rd(a, d, r);
    `CHK(r, (a > ADDR_CODES) ? RESP_SLVERR : RESP_OKAY)
  endtask : rd

  // Read results are matched against the oldest noted expectation
  always @(posedge aclk) if (s_axi_rvalid && s_axi_rready) begin
    dcw_exp_t e;
    e = exp_q.pop_front();
    `CHK(s_axi_rdata & e.m, e.v)
  end

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      wrap_up();
    end
  end

  initial begin
    logic [31:0] w;
    logic [3:0] ct;
    logic ok;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_CTRL_WORD, 32'hFC00_0000, CTRL_WORD_RST);
    rd(ADDR_CBK_TIME, 32'h0000_FFFF, 32'h0000_01F4);
    rd(8'h40, 32'h0, 32'h0);
    wr(8'h40, 32'hFFFF_FFFF);
    wr(ADDR_IRQ_MASK, 32'h0);
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      w = seed | 32'h8400_0000;
      ct = (i % 3 == 0) ? 4'h0 : ((i % 3 == 1) ? CTYPE_FREQ_CL : CTYPE_SPEED_CL);
      ok = seed[0] && (ct != 4'h0);
      wr(ADDR_CONFIG, {27'h0, seed[0], ct});
      wr(ADDR_CTRL_WORD, w);
      repeat (3) @(posedge aclk);
      `CHK({slave_torque, master_speed}, {ok && w[27], ok && !w[27]})
      `CHK({alarm_one, alarm_two, param_set_two}, {!w[28], !w[29], w[30]})
      `CHK(fault_active, 1'b0)
      rd(ADDR_CODES, 32'h00FF_FF00, {8'h0, w[29] ? 8'h0 : EXT_ALARM_TWO_CODE,
         w[28] ? 8'h0 : EXT_ALARM_ONE_CODE, 8'h0});
    end
    // Alarm interrupt masked, unmasked and cleared
    wr(ADDR_CTRL_WORD, 32'hEC00_0000);
    wr(ADDR_IRQ_STAT, 32'hF);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b0)
    wr(ADDR_IRQ_MASK, 32'h2);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b1)
    wr(ADDR_CTRL_WORD, CTRL_WORD_RST);
    wr(ADDR_IRQ_STAT, 32'hF);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b0)
    // Checkback window expires, then the contactor reports closed
    wr(ADDR_IRQ_MASK, 32'h8);
    wr(ADDR_CBK_TIME, 32'h1);
    wr(ADDR_CTRL_WORD, 32'h7C00_0000);
    wr(ADDR_CONFIG, 32'h74);
    repeat (20) @(posedge aclk);
    `CHK({contactor_confirmed, irq}, 2'b01)
    wr(ADDR_CTRL_WORD, CTRL_WORD_RST);
    repeat (4) @(posedge aclk);
    `CHK(contactor_confirmed, 1'b1)
    wr(ADDR_IRQ_STAT, 32'hF);
    wr(ADDR_IRQ_MASK, 32'h1);
    // External fault ignored until ready, then delayed
    wr(ADDR_CONFIG, 32'h34);
    wr(ADDR_CTRL_WORD, 32'hF800_0000);
    repeat (40) @(posedge aclk);
    `CHK(fault_active, 1'b0)
    wr(ADDR_CONFIG, 32'h74);
    repeat (10) @(posedge aclk);
    `CHK(fault_active, 1'b0)
    // Clock enable low freezes the fault delay count
    ce <= 1'b0;
    repeat (15) @(posedge aclk);
    ce <= 1'b1;
    `CHK(fault_active, 1'b0)
    repeat (20) @(posedge aclk);
    `CHK({fault_active, pulse_inhibit, contactor_open, irq}, 4'hF)
    rd(ADDR_CODES, 32'h0000_00FF, {24'h0, EXT_FAULT_TWO_CODE});
    wr(ADDR_CTRL_WORD, CTRL_WORD_RST);
    wr(ADDR_CONFIG, 32'hF4);
    repeat (3) @(posedge aclk);
    `CHK({fault_active, contactor_open}, 2'b00)
    wrap_up();
  end
endmodule : drive_control_word_upper_bits_bench
